/* File: verilog/iep_pkg.sv */
// iep_pkg: offsets, field positions and reset values for the
// interrupt enable and priority block.
// assumes a 32-bit apb slave with byte addresses as printed.
package iep_pkg;
  localparam int          IEP_NSRC          = 7;
  localparam logic [11:0] IEP_ENABLE_OFS    = 12'h0a8;
  localparam logic [11:0] IEP_PRIORITY_OFS  = 12'h0b8;
  localparam logic [11:0] IEP_PENDING_OFS   = 12'h0c0;
  localparam logic [11:0] IEP_VECTOR_OFS    = 12'h0c4;
  localparam int          IEP_GLOBAL_BIT    = 7;
  localparam int          IEP_PRIO_TOP_BIT  = 7;
  localparam logic [7:0]  IEP_ENABLE_RST    = 8'h00;
  localparam logic [6:0]  IEP_PRIORITY_RST  = 7'h00;
  localparam logic [2:0]  IEP_NONE_ID       = 3'h7;
  // source positions, bit 0 upward
  localparam int IEP_SRC_EXT0   = 0;
  localparam int IEP_SRC_TIMER0 = 1;
  localparam int IEP_SRC_EXT1   = 2;
  localparam int IEP_SRC_TIMER1 = 3;
  localparam int IEP_SRC_UART0  = 4;
  localparam int IEP_SRC_TIMER2 = 5;
  localparam int IEP_SRC_UART1  = 6;

  typedef enum logic [2:0]
  {
    IEP_IDLE = 3'b001,
    IEP_LOW  = 3'b010,
    IEP_HIGH = 3'b100
  } iep_level_t;

  // lowest set bit wins; returns none id when empty
  function automatic logic [2:0] iep_first(input logic [6:0] v);
    logic [2:0] id;
    id = IEP_NONE_ID;
    for (int i = IEP_NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        id = 3'(i);
      end
    end
    return id;
  endfunction
endpackage

/* File: verilog/iep_select.sv */
// iep_select: picks the winning source among gated requests.
// assumes requests are already masked by the enables.
`timescale 1ns/1ps
`default_nettype none
module iep_select
  import iep_pkg::*;
(
  // requests and levels
  input  wire logic [6:0] req,
  input  wire logic [6:0] high_sel,
  // winner
  output logic            hi_valid,
  output logic            lo_valid,
  output logic [2:0]      hi_id,
  output logic [2:0]      lo_id
);
  logic [6:0] hi_req;
  logic [6:0] lo_req;

  assign hi_req   = req & high_sel;
  assign lo_req   = req & ~high_sel;
  assign hi_valid = |hi_req;
  assign lo_valid = |lo_req;
  assign hi_id    = iep_first(hi_req);
  assign lo_id    = iep_first(lo_req);
endmodule
`default_nettype wire

/* File: verilog/iep_apb.sv */
// iep_apb: apb slave front end, zero wait state.
// assumes apb master holds the request until pready.
`timescale 1ns/1ps
`default_nettype none
module iep_apb
  import iep_pkg::*;
(
  // apb
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] rdata_mux,
  output logic             pready,
  output logic [31:0]      prdata,
  // decoded access
  output logic             wr_stb,
  output logic             rd_stb
);
  assign pready = 1'b1;
  assign wr_stb = psel & penable & pwrite;
  assign rd_stb = psel & ~penable & ~pwrite;

  // data captured in setup so it stands through the access phase
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata <= 32'h0;
    end
    else if (rd_stb)
    begin
      prdata <= rdata_mux;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/iep_top.sv */
// iep_top: interrupt enable and two-level priority for seven sources.
// assumes request lines are levels synchronous to clk and held by the
// source until serviced; the core acknowledges and returns by pulses.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - top enable bit gates every source
// - enable bits six to zero per source
// - priority bit seven reads one, unstored
// - priority bits six to zero per source
// - priority one means high level
// - all seven priority bits raise sources
module iep_top
  import iep_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // peripheral requests
  input  wire logic [6:0]  src_req,
  // core side
  output logic             irq_valid,
  output logic [2:0]       irq_id,
  output logic             irq_is_high,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  output logic [1:0]       in_service
);
  logic [7:0]  enable_r;
  logic [6:0]  priority_r;
  logic [6:0]  gated;
  logic        hi_valid;
  logic        lo_valid;
  logic [2:0]  hi_id;
  logic [2:0]  lo_id;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata_mux;
  logic        irq_valid_nxt;
  logic [2:0]  irq_id_nxt;
  logic        irq_high_nxt;
  logic        low_act_r;
  logic        high_act_r;
  iep_level_t  level_r;

  iep_apb u_apb
  (
    .clk       (clk),
    .srst      (srst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .rdata_mux (rdata_mux),
    .pready    (pready),
    .prdata    (prdata),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb)
  );

  assign pslverr = 1'b0;

  // enable register, global bit on top
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      enable_r <= IEP_ENABLE_RST;
    end
    else if (wr_stb && paddr == IEP_ENABLE_OFS)
    begin
      enable_r <= pwdata[7:0];
    end
  end

  // priority register; bit seven has no flop
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      priority_r <= IEP_PRIORITY_RST;
    end
    else if (wr_stb && paddr == IEP_PRIORITY_OFS)
    begin
      priority_r <= pwdata[6:0];
    end
  end

  always_comb
  begin
    rdata_mux = 32'h0;
    if (paddr == IEP_ENABLE_OFS)
    begin
      rdata_mux = {24'h0, enable_r};
    end
    else if (paddr == IEP_PRIORITY_OFS)
    begin
      rdata_mux = {24'h0, 1'b1, priority_r};
    end
    else if (paddr == IEP_PENDING_OFS)
    begin
      rdata_mux = {25'h0, src_req};
    end
    else if (paddr == IEP_VECTOR_OFS)
    begin
      rdata_mux = {26'h0, high_act_r, low_act_r, irq_valid, irq_id};
    end
  end

  // global gate over individual gates
  assign gated = enable_r[IEP_GLOBAL_BIT] ?
                 (src_req & enable_r[6:0]) : 7'h00;

  iep_select u_sel
  (
    .req      (gated),
    .high_sel (priority_r),
    .hi_valid (hi_valid),
    .lo_valid (lo_valid),
    .hi_id    (hi_id),
    .lo_id    (lo_id)
  );

  // high requests may preempt a low service; nothing preempts high
  always_comb
  begin
    irq_valid_nxt = 1'b0;
    irq_id_nxt    = IEP_NONE_ID;
    irq_high_nxt  = 1'b0;
    if (hi_valid && !high_act_r)
    begin
      irq_valid_nxt = 1'b1;
      irq_id_nxt    = hi_id;
      irq_high_nxt  = 1'b1;
    end
    else if (lo_valid && !high_act_r && !low_act_r)
    begin
      irq_valid_nxt = 1'b1;
      irq_id_nxt    = lo_id;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_valid   <= 1'b0;
      irq_id      <= IEP_NONE_ID;
      irq_is_high <= 1'b0;
    end
    else
    begin
      irq_valid   <= irq_valid_nxt & ~irq_ack;
      irq_id      <= irq_id_nxt;
      irq_is_high <= irq_high_nxt;
    end
  end

  // service nesting: ack enters the level shown, return leaves the top
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      low_act_r  <= 1'b0;
      high_act_r <= 1'b0;
      level_r    <= IEP_IDLE;
    end
    else if (irq_ack && irq_valid)
    begin
      if (irq_is_high)
      begin
        high_act_r <= 1'b1;
        level_r    <= IEP_HIGH;
      end
      else
      begin
        low_act_r <= 1'b1;
        level_r   <= IEP_LOW;
      end
    end
    else if (irq_return)
    begin
      case (level_r)
        IEP_HIGH:
        begin
          high_act_r <= 1'b0;
          level_r    <= low_act_r ? IEP_LOW : IEP_IDLE;
        end
        IEP_LOW:
        begin
          low_act_r <= 1'b0;
          level_r   <= IEP_IDLE;
        end
        default:
        begin
          level_r <= IEP_IDLE;
        end
      endcase
    end
  end

  assign in_service = {high_act_r, low_act_r};
endmodule
`default_nettype wire

/* File: dv/iep_core_model.sv */
// iep_core_model: core side, acks offers and returns on command.
// assumes take and ret are driven on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module iep_core_model
(
  // clock, offer and commands
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic irq_valid,
  input  wire logic take,
  input  wire logic ret,
  // core pulses
  output logic      irq_ack,
  output logic      irq_return
);
  // acks only a live offer and never two cycles running, so the pulse stays one cycle wide
  always_ff @(posedge clk)
  begin
    irq_ack <= !srst && take && irq_valid && !irq_ack;
  end
  always_ff @(posedge clk)
  begin
    irq_return <= !srst && ret && !irq_return;
  end
endmodule
`default_nettype wire

/* File: dv/iep_top_asserts.sv */
// iep_top_asserts: port checks for iep_top.
// assumes the bind below; registers are shadowed from apb writes.
`timescale 1ns/1ps
`default_nettype none
module iep_top_asserts
  import iep_pkg::*;
(
  // snooped ports
  input wire logic        clk, srst, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [6:0]  src_req,
  input wire logic        irq_valid, irq_is_high, irq_ack,
  input wire logic [2:0]  irq_id,
  input wire logic [1:0]  in_service
);
  logic [7:0] e;
  logic [6:0] p;
  // shadows one cycle late, matching the registered offer
  logic [7:0] e_d;
  logic [6:0] p_d;
  always_ff @(posedge clk)
  begin
    e_d <= e;
    p_d <= p;
  end
  wire logic  w = psel && penable && pwrite;
  always_ff @(posedge clk)
  begin
    if (srst)
      e <= IEP_ENABLE_RST;
    else if (w && paddr == IEP_ENABLE_OFS)
      e <= pwdata[7:0];
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      p <= IEP_PRIORITY_RST;
    else if (w && paddr == IEP_PRIORITY_OFS)
      p <= pwdata[6:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_global_gate: assert property (
    $rose(irq_valid) |-> $past(e[7])) else $error("offer while off");
  a_src_enable: assert property (
    irq_valid |-> e_d[irq_id]) else $error("disabled source");
  a_prio_read: assert property (
    psel && penable && !pwrite && paddr == IEP_PRIORITY_OFS
    |-> prdata[7:0] == {1'b1, p}) else $error("priority readback");
  a_high_level: assert property (
    irq_valid |-> irq_is_high == p_d[irq_id]) else $error("level");
  a_high_first: assert property (
    irq_valid && !irq_is_high |-> $past((src_req & e[6:0] & p) == 7'h0))
    else $error("low ahead of high");
  a_ack_takes: assert property (
    irq_valid && irq_ack |=> !irq_valid && in_service != 2'h0)
    else $error("ack not taken");
  a_high_busy: assert property (
    in_service[1] && $past(in_service[1]) |-> !irq_valid)
    else $error("offer in high service");
endmodule
bind iep_top iep_top_asserts i_chk (.clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .src_req, .irq_valid,
  .irq_is_high, .irq_ack, .irq_id, .in_service);
`default_nettype wire

/* File: dv/iep_top_tb.sv */
// iep_top_tb: register and priority tests for iep_top.
// assumes the core model acks and returns on command.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, x) begin comparisons++; if ((a) !== (x)) begin \
  mismatches++; $display("[FAIL] %0t %h %h", $time, a, x); end end
module iep_top_tb
  import iep_pkg::*;
;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic take = 0, ret = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [6:0]  src_req = 7'h0;
  wire logic   pready, pslverr, irq_valid, irq_is_high, irq_ack;
  wire logic   irq_return;
  wire logic [31:0] prdata;
  wire logic [2:0]  irq_id;
  wire logic [1:0]  in_service;
  int mismatches = 0, comparisons = 0;
  iep_top i_dut (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .src_req, .irq_valid,
    .irq_id, .irq_is_high, .irq_ack, .irq_return, .in_service);
  iep_core_model i_core (.clk, .srst, .irq_valid, .take, .ret,
    .irq_ack, .irq_return);
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic core(input logic t, input logic r);
    @(posedge clk);
    take <= t;
    ret <= r;
    @(posedge clk);
    take <= 0;
    ret <= 0;
    cyc(3);
  endtask
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #300000;
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 0;
    apb(1, 12'h0ac, 8'hff);
    apb(0, IEP_ENABLE_OFS, 0);
    `CHK(rd, 32'h0)
    apb(0, IEP_PRIORITY_OFS, 0);
    `CHK(rd, 32'h80)
    `CHK({pready, pslverr}, 2'b10)
    apb(1, IEP_PRIORITY_OFS, 8'h7f);
    apb(0, IEP_PRIORITY_OFS, 0);
    `CHK(rd, 32'hff)
    src_req <= 7'h7f;
    apb(0, IEP_PENDING_OFS, 0);
    `CHK(rd, 32'h7f)
    apb(1, IEP_ENABLE_OFS, 8'h7f);
    cyc(3);
    `CHK(irq_valid, 1'b0)
    for (int i = 0; i < 7; i++)
    begin
      apb(1, IEP_ENABLE_OFS, 8'h80 | (8'h1 << i));
      apb(1, IEP_PRIORITY_OFS, 8'h0);
      cyc(3);
      `CHK({irq_valid, irq_is_high, irq_id}, 5'h10 | 5'(i))
      apb(1, IEP_ENABLE_OFS, 8'hff);
      apb(1, IEP_PRIORITY_OFS, 8'h1 << i);
      cyc(3);
      `CHK({irq_valid, irq_is_high, irq_id}, 5'h18 | 5'(i))
    end
    apb(1, IEP_PRIORITY_OFS, 8'h0);
    cyc(3);
    core(1, 0);
    `CHK({in_service, irq_valid}, 3'b010)
    apb(1, IEP_PRIORITY_OFS, 8'h40);
    cyc(3);
    `CHK({irq_valid, irq_is_high, irq_id}, 5'h1e)
    core(1, 0);
    `CHK({in_service, irq_valid}, 3'b110)
    core(0, 1);
    `CHK(in_service, 2'b01)
    core(0, 1);
    `CHK({in_service, irq_valid, irq_id}, 6'h0e)
    apb(0, IEP_VECTOR_OFS, 0);
    `CHK(rd, 32'h0e)
    summarize();
  end
endmodule
`default_nettype wire
